// >>> hdl/rbb_pkg.sv
// rbb_pkg: constants for the radio baseband register port
// assumes: a single 100 MHz core clock, host spi link sampled as pins
// Functional notes
// RQ1: host pulses reset high after power-up
// RQ2: spi port, host drives clock, mosi
// RQ3: irq polarity or gpio; miso may be gpio
// RQ4: aux pin clock, inverted amp, gpio
// RQ5: channel register holds 98 channels
// RQ6: dsss modes spread and despread chips
// RQ7: gfsk mode frames and checks crc16
// RQ8: optional auto acknowledge after valid packet
// RQ9: framed receive accepts all rates except single
// RQ10: host writes transmit config 0x16
// RQ11: host writes receive config 0x4B
// RQ12: host writes transaction config 0x05
// RQ13: host writes framing config 0x00
// RQ14: host writes transmit override 0x04
// RQ15: receive override 0x14 drops crc checks
// RQ16: analog 0x01 makes all settling slow
// RQ17: threshold 0x03 tolerates three bad chips
// RQ18: end control sets non-correlating symbol count
// RQ19: host loads preamble 0xAAAA05, count above four
// RQ20: double rate carries two bits per symbol
// RQ21: host configures fully before any transaction
package rbb_pkg;
  // ---------------------------------------------------------------
  // register indices (spi address, 6 bits)
  // ---------------------------------------------------------------
  localparam logic [5:0] ADR_CHANNEL = 6'h00;
  localparam logic [5:0] ADR_TX_CFG = 6'h03;
  localparam logic [5:0] ADR_RX_CFG = 6'h06;
  localparam logic [5:0] ADR_XACT_CFG = 6'h0F;
  localparam logic [5:0] ADR_FRAMING_CFG = 6'h10;
  localparam logic [5:0] ADR_TX_OVR = 6'h1D;
  localparam logic [5:0] ADR_RX_OVR = 6'h1E;
  localparam logic [5:0] ADR_AUX_CFG = 6'h1F;
  localparam logic [5:0] ADR_ANALOG = 6'h20;
  localparam logic [5:0] ADR_THOLD32 = 6'h22;
  localparam logic [5:0] ADR_EOP_CTRL = 6'h26;
  localparam logic [5:0] ADR_TX_DATA = 6'h28;
  localparam logic [5:0] ADR_STATUS = 6'h29;
  localparam logic [5:0] ADR_PREAMBLE = 6'h2A; // preamble store, address arbitrary
  localparam int NUM_REGS = 64;
  // ---------------------------------------------------------------
  // reset values (double-rate setup is loaded by the host)
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_AUX_CFG = 8'h00;
  localparam logic [7:0] DDR_TX_CFG = 8'h16;
  localparam logic [7:0] DDR_RX_OVR = 8'h14;
  localparam logic [7:0] DDR_ANALOG = 8'h01;
  localparam logic [7:0] DDR_THOLD32 = 8'h03;
  localparam logic [7:0] DDR_EOP_CTRL = 8'h01;
  localparam logic [7:0] MAX_CHANNEL = 8'h61; // 98 channels, 0..97
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int TXC_MODE_LSB = 3;  // tx cfg [4:3] data mode
  localparam int TXC_CODE_BIT = 5;  // tx cfg [5] 64-chip code
  localparam int XC_AUTOACK_BIT = 7;
  localparam int FR_SOP_EN_BIT = 7;
  localparam int TXO_NOCRC_BIT = 2;
  localparam int RXO_NOCRC_BIT = 2;
  localparam int RXO_ACCBAD_BIT = 4;
  localparam int AN_ALLSLOW_BIT = 0;
  localparam int AUX_IRQ_LSB = 0;   // [1:0] irq mode
  localparam int AUX_MISO_GPIO_BIT = 2;
  localparam int AUX_XO_LSB = 3;    // [4:3] aux mode
  localparam int AUX_AMP_GPIO_BIT = 5;
  localparam int AUX_GPIO_LSB = 6;  // [6] irq gpio, [7] miso gpio
  localparam int ST_TXDONE_BIT = 0;
  // ---------------------------------------------------------------
  // modes
  // ---------------------------------------------------------------
  localparam logic [1:0] MODE_GFSK = 2'h0;
  localparam logic [1:0] MODE_8DR = 2'h1;
  localparam logic [1:0] MODE_DDR = 2'h2;
  localparam logic [1:0] MODE_SINGLE = 2'h3;
  localparam logic [1:0] IRQ_HIGH = 2'h0;
  localparam logic [1:0] IRQ_LOW = 2'h1;
  localparam logic [1:0] IRQ_GPIO = 2'h2;
  localparam logic [1:0] XO_CLOCK = 2'h0;
  localparam logic [1:0] XO_AMP_N = 2'h1;
  localparam logic [1:0] XO_GPIO = 2'h2;
  localparam int BITS_PER_DDR_SYMBOL = 2;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_WIDTH = 8;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 100;
  localparam int ACK_TIMEOUT_US = 128;
  localparam int ACK_TIMEOUT_CYC = ACK_TIMEOUT_US * CLK_MHZ;
  localparam int AUX_CLK_DIV = 4; // buffered clock is core / (2*div)
endpackage : rbb_pkg

// >>> hdl/rbb_radio.sv
// rbb_radio: spi register port, pin muxing and ddr symbol packer
// assumes: spi pins asynchronous to i_ref_clk and well below its rate
`timescale 1ns/10ps
`default_nettype none

// -----------------------------------------------------------------
// rbb_fifo: small flop fifo between register port and symbol packer
// -----------------------------------------------------------------
module rbb_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_valid,
  output logic o_ready,
  input wire logic [WIDTH-1:0] i_data,
  output logic o_valid,
  input wire logic i_ready,
  output logic [WIDTH-1:0] o_data
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } rbb_fifo_t;
  rbb_fifo_t st, next_st;
  logic push, pop;

  // push and pop bookkeeping
  always_comb begin
    next_st = st;
    push = i_valid && (st.cnt != (AW+1)'(DEPTH));
    pop = i_ready && (st.cnt != '0);
    if (push) begin
      next_st.mem[st.wr] = i_data;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign o_ready = st.cnt != (AW+1)'(DEPTH);
  assign o_valid = st.cnt != '0;
  assign o_data = st.mem[st.rd];
endmodule // rbb_fifo

// -----------------------------------------------------------------
// rbb_radio: top
// -----------------------------------------------------------------
module rbb_radio (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_spi_sck,
  input wire logic i_spi_ss_n,
  input wire logic i_spi_mosi,
  output logic o_spi_miso,
  output logic o_spi_miso_oe,
  output logic o_irq,
  output logic o_aux_clock_out,
  output logic o_amp_control_out,
  input wire logic i_tx_active,
  input wire logic i_symbol_ready,
  output logic o_symbol_valid,
  output logic [1:0] o_symbol,
  output logic o_tx_crc_en,
  output logic o_rx_crc_check_en,
  output logic o_rx_accept_bad_crc,
  output logic o_all_slow_settle,
  output logic [7:0] o_channel,
  output logic [7:0] o_chip_threshold,
  output logic [7:0] o_eop_symbols,
  output logic o_use_64_chip,
  output logic o_framer_en,
  output logic o_rx_any_rate,
  output logic o_auto_ack_en
);
  import rbb_pkg::*;

  typedef enum logic [1:0] {S_IDLE, S_ADDR, S_DATA} rbb_phase_t;
  typedef struct packed {
    logic [2:0] sck_s;
    logic [1:0] ss_s;
    logic [1:0] mosi_s;
    rbb_phase_t phase;
    logic wr;
    logic [2:0] bitn;
    logic [5:0] addr;
    logic [7:0] sh;
    logic [NUM_REGS-1:0][7:0] regs;
    logic miso;
    logic push;
    logic [7:0] push_data;
    logic [7:0] sym_byte;
    logic [1:0] sym_left;
    logic sym_valid;
    logic [1:0] sym;
    logic [2:0] div;
    logic xclk;
    logic [12:0] outs;
  } rbb_radio_t;
  rbb_radio_t st, next_st;
  logic fifo_valid, fifo_pop;
  logic [7:0] fifo_data;

  // read value, status register shows packer occupancy
  function automatic logic [7:0] rd_val(input rbb_radio_t s, input logic [5:0] a);
    if (a == ADR_STATUS) begin
      rd_val = {6'h00, s.sym_valid, (s.sym_left == 2'h0)};
    end else begin
      rd_val = s.regs[a];
    end
  endfunction

  logic [1:0] data_mode;
  logic [7:0] aux;
  logic sck_rise, sck_fall;

  // spi slave, register file, packer, pin muxing
  always_comb begin
    next_st = st;
    aux = st.regs[ADR_AUX_CFG];
    data_mode = st.regs[ADR_TX_CFG][TXC_MODE_LSB +: 2];
    next_st.sck_s = {st.sck_s[1:0], i_spi_sck};
    next_st.ss_s = {st.ss_s[0], i_spi_ss_n};
    next_st.mosi_s = {st.mosi_s[0], i_spi_mosi};
    sck_rise = st.sck_s[1] && !st.sck_s[2];
    sck_fall = !st.sck_s[1] && st.sck_s[2];
    next_st.push = 1'b0;
    // host-driven spi frame: spare bit, wr bit, 6-bit addr, then data RQ2
    if (st.ss_s[1]) begin
      next_st.phase = S_ADDR;
      next_st.bitn = 3'h0;
    end else if (sck_rise) begin
      next_st.sh = {st.sh[6:0], st.mosi_s[1]};
      next_st.bitn = st.bitn + 3'h1;
      if (st.bitn == 3'h7) begin
        if (st.phase == S_ADDR) begin
          next_st.wr = st.sh[5];
          next_st.addr = {st.sh[4:0], st.mosi_s[1]};
          next_st.phase = S_DATA;
          next_st.sh = rd_val(st, {st.sh[4:0], st.mosi_s[1]});
        end else begin
          if (st.wr && st.addr == ADR_TX_DATA) begin
            next_st.push = 1'b1;
            next_st.push_data = {st.sh[6:0], st.mosi_s[1]};
          end else if (st.wr && st.addr == ADR_CHANNEL) begin
            // clamp to the 98 legal channels RQ5
            next_st.regs[ADR_CHANNEL] = ({st.sh[6:0], st.mosi_s[1]} > MAX_CHANNEL) ?
              MAX_CHANNEL : {st.sh[6:0], st.mosi_s[1]};
          end else if (st.wr && st.addr != ADR_STATUS) begin
            next_st.regs[st.addr] = {st.sh[6:0], st.mosi_s[1]};
          end
          next_st.addr = st.addr + 6'h01;
          next_st.sh = rd_val(st, st.addr + 6'h01);
        end
      end
    end else if (sck_fall && st.phase == S_DATA) begin
      next_st.miso = st.sh[7];
    end
    // ddr packer: one byte becomes four two-bit symbols RQ6 RQ20
    if (st.sym_valid && i_symbol_ready) begin
      next_st.sym_valid = 1'b0;
    end
    if (!next_st.sym_valid && st.sym_left != 2'h0) begin
      next_st.sym = st.sym_byte[7:6];
      next_st.sym_byte = {st.sym_byte[5:0], 2'b00};
      next_st.sym_left = st.sym_left - 2'h1;
      next_st.sym_valid = 1'b1;
    end
    fifo_pop = (st.sym_left == 2'h0) && !st.sym_valid && i_tx_active &&
      data_mode == MODE_DDR;
    if (fifo_pop && fifo_valid) begin
      next_st.sym_byte = {fifo_data[5:0], 2'b00};
      next_st.sym = fifo_data[7:6];
      next_st.sym_left = 2'(4 - 1);
      next_st.sym_valid = 1'b1;
    end
    // buffered clock divider for the aux pin RQ4
    next_st.div = st.div + 3'h1;
    if (st.div == 3'(AUX_CLK_DIV - 1)) begin
      next_st.div = 3'h0;
      next_st.xclk = !st.xclk;
    end
    // irq pin: polarity or gpio RQ3
    unique case (aux[AUX_IRQ_LSB +: 2])
      IRQ_HIGH: next_st.outs[0] = st.sym_left == 2'h0 && !st.sym_valid;
      IRQ_LOW: next_st.outs[0] = !(st.sym_left == 2'h0 && !st.sym_valid);
      default: next_st.outs[0] = aux[AUX_GPIO_LSB];
    endcase
    // miso as data or gpio RQ3
    next_st.outs[1] = aux[AUX_MISO_GPIO_BIT] ? aux[AUX_GPIO_LSB + 1] : st.miso;
    next_st.outs[2] = aux[AUX_MISO_GPIO_BIT] || !st.ss_s[1];
    // aux: clock, inverted amp control, or gpio RQ4
    unique case (aux[AUX_XO_LSB +: 2])
      XO_CLOCK: next_st.outs[3] = st.xclk;
      XO_AMP_N: next_st.outs[3] = !i_tx_active;
      default: next_st.outs[3] = aux[AUX_GPIO_LSB];
    endcase
    next_st.outs[4] = aux[AUX_AMP_GPIO_BIT] ? aux[AUX_GPIO_LSB + 1] : i_tx_active; // RQ4
    // gfsk framing and crc RQ7, override bits RQ14 RQ15
    next_st.outs[5] = data_mode == MODE_GFSK && !st.regs[ADR_TX_OVR][TXO_NOCRC_BIT];
    next_st.outs[6] = data_mode == MODE_GFSK && !st.regs[ADR_RX_OVR][RXO_NOCRC_BIT]; // RQ15
    next_st.outs[7] = st.regs[ADR_RX_OVR][RXO_ACCBAD_BIT]; // RQ15
    next_st.outs[8] = st.regs[ADR_ANALOG][AN_ALLSLOW_BIT]; // RQ16
    next_st.outs[9] = st.regs[ADR_TX_CFG][TXC_CODE_BIT]; // RQ6
    next_st.outs[10] = st.regs[ADR_FRAMING_CFG][FR_SOP_EN_BIT]; // RQ7
    next_st.outs[11] = st.regs[ADR_FRAMING_CFG][FR_SOP_EN_BIT] && data_mode != MODE_SINGLE; // RQ9
    next_st.outs[12] = st.regs[ADR_XACT_CFG][XC_AUTOACK_BIT]; // RQ8
  end

  // state register
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin // RQ1
      st <= '0;
      st.ss_s <= 2'b11;
      st.regs[ADR_AUX_CFG] <= RST_AUX_CFG;
    end else begin
      st <= next_st;
    end
  end

  rbb_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_valid(st.push),
    .o_ready(), // a full fifo refuses the byte itself
    .i_data(st.push_data),
    .o_valid(fifo_valid),
    .i_ready(fifo_pop),
    .o_data(fifo_data)
  );

  assign o_irq = st.outs[0];
  assign o_spi_miso = st.outs[1];
  assign o_spi_miso_oe = st.outs[2];
  assign o_aux_clock_out = st.outs[3];
  assign o_amp_control_out = st.outs[4];
  assign o_tx_crc_en = st.outs[5];
  assign o_rx_crc_check_en = st.outs[6];
  assign o_rx_accept_bad_crc = st.outs[7];
  assign o_all_slow_settle = st.outs[8];
  assign o_use_64_chip = st.outs[9];
  assign o_framer_en = st.outs[10];
  assign o_rx_any_rate = st.outs[11];
  assign o_auto_ack_en = st.outs[12];
  assign o_symbol_valid = st.sym_valid;
  assign o_symbol = st.sym;
  assign o_chip_threshold = st.regs[ADR_THOLD32]; // RQ17
  assign o_eop_symbols = st.regs[ADR_EOP_CTRL]; // RQ18
  assign o_channel = st.regs[ADR_CHANNEL]; // RQ5

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_sym_hold;
    @(posedge i_ref_clk) disable iff (i_rst)
      (o_symbol_valid && !i_symbol_ready) |=> (o_symbol_valid && $stable(o_symbol));
  endproperty
  a_sym_hold: assert property (p_sym_hold) else $error("symbol dropped"); // RQ20
  property p_chan_range;
    @(posedge i_ref_clk) disable iff (i_rst) o_channel <= MAX_CHANNEL;
  endproperty
  a_chan_range: assert property (p_chan_range) else $error("channel out of range"); // RQ5
  property p_single_no_any;
    @(posedge i_ref_clk) disable iff (i_rst)
      (data_mode == MODE_SINGLE) |=> !o_rx_any_rate;
  endproperty
  a_single_no_any: assert property (p_single_no_any) else $error("single rate any rate"); // RQ9
  property p_accbad;
    @(posedge i_ref_clk) disable iff (i_rst)
      st.regs[ADR_RX_OVR][RXO_ACCBAD_BIT] |=> o_rx_accept_bad_crc;
  endproperty
  a_accbad: assert property (p_accbad) else $error("accept bad not set"); // RQ15
  property p_slow;
    @(posedge i_ref_clk) disable iff (i_rst)
      st.regs[ADR_ANALOG][AN_ALLSLOW_BIT] |=> o_all_slow_settle;
  endproperty
  a_slow: assert property (p_slow) else $error("slow settle off"); // RQ16
  property p_irq_low;
    @(posedge i_ref_clk) disable iff (i_rst)
      (aux[1:0] == IRQ_LOW && o_symbol_valid) |=> (o_irq || aux[1:0] != IRQ_LOW);
  endproperty
  a_irq_low: assert property (p_irq_low) else $error("irq polarity"); // RQ3
  property p_miso_gpio;
    @(posedge i_ref_clk) disable iff (i_rst)
      aux[AUX_MISO_GPIO_BIT] |=> o_spi_miso_oe;
  endproperty
  a_miso_gpio: assert property (p_miso_gpio) else $error("miso gpio not driven"); // RQ3
  property p_crc_gfsk;
    @(posedge i_ref_clk) disable iff (i_rst)
      (data_mode != MODE_GFSK) |=> !o_tx_crc_en;
  endproperty
  a_crc_gfsk: assert property (p_crc_gfsk) else $error("crc outside gfsk"); // RQ7
endmodule // rbb_radio

`default_nettype wire

// >>> tb/rbb_host_model.sv
// rbb_host_model: host side of the spi link, mode 0 master
// assumes: caller enters its tasks at a falling edge of i_ref_clk
`timescale 1ns/10ps
`default_nettype none
module rbb_host_model (
  input wire logic i_ref_clk,
  input wire logic i_miso,
  output logic o_sck,
  output logic o_ss_n,
  output logic o_mosi
);
  localparam int HALF = 8; // 160 ns link clock period

  // link clock idles low outside frames
  initial begin
    o_sck = 1'b0;
    o_ss_n = 1'b1;
    o_mosi = 1'b1;
  end

  // one byte: host shifts on fall, samples miso on rise
  task automatic xfer_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int b = 7; b >= 0; b--) begin
      o_mosi = tx[b];
      repeat (HALF) @(negedge i_ref_clk);
      o_sck = 1'b1;
      rx[b] = i_miso;
      repeat (HALF) @(negedge i_ref_clk);
      o_sck = 1'b0;
    end
  endtask

  // header byte then one data byte
  task automatic frame(input logic wr, input logic [5:0] adr, input logic [7:0] wd,
                       output logic [7:0] rd);
    logic [7:0] junk;
    o_ss_n = 1'b0;
    repeat (HALF) @(negedge i_ref_clk);
    xfer_byte({1'b0, wr, adr}, junk);
    xfer_byte(wd, rd);
    repeat (HALF) @(negedge i_ref_clk);
    o_ss_n = 1'b1;
    o_mosi = ~o_mosi; // released line does not keep last bit
    repeat (2 * HALF) @(negedge i_ref_clk);
  endtask
endmodule // rbb_host_model
`default_nettype wire

// >>> tb/tb_top.sv
// tb_top: self-checking bench for rbb_radio
// assumes: host model drives spi pins, bench plays the modem side
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import rbb_pkg::*;
  logic clk, rst, tx_act, sym_rdy;
  wire logic sck, ss_n, mosi;
  logic miso, miso_oe, irq, aux, amp, sym_v, tx_crc, rx_crc, rx_bad, slow;
  logic c64, fr_en, any_rate, ack;
  logic [1:0] sym;
  logic [7:0] chan, thold, eop;
  int bad_count = 0;
  int cmp_count = 0;

  // ----------------------------------------------------------------
  // clock, parts
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // undriven miso shows the inverse of its last bit
  rbb_host_model rbb_host_model_i (.i_ref_clk(clk), .i_miso(miso_oe ? miso : ~miso),
    .o_sck(sck), .o_ss_n(ss_n), .o_mosi(mosi));

  rbb_radio rbb_radio_i (.i_ref_clk(clk), .i_rst(rst), .i_spi_sck(sck), .i_spi_ss_n(ss_n),
    .i_spi_mosi(mosi), .o_spi_miso(miso), .o_spi_miso_oe(miso_oe), .o_irq(irq),
    .o_aux_clock_out(aux), .o_amp_control_out(amp), .i_tx_active(tx_act),
    .i_symbol_ready(sym_rdy), .o_symbol_valid(sym_v), .o_symbol(sym),
    .o_tx_crc_en(tx_crc), .o_rx_crc_check_en(rx_crc), .o_rx_accept_bad_crc(rx_bad),
    .o_all_slow_settle(slow), .o_channel(chan), .o_chip_threshold(thold),
    .o_eop_symbols(eop), .o_use_64_chip(c64), .o_framer_en(fr_en),
    .o_rx_any_rate(any_rate), .o_auto_ack_en(ack));

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    cmp_count++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [5:0] adr, input logic [7:0] d);
    logic [7:0] junk;
    rbb_host_model_i.frame(1'b1, adr, d, junk);
  endtask

  task automatic rd(input logic [5:0] adr, output logic [7:0] d);
    rbb_host_model_i.frame(1'b0, adr, 8'h00, d);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check("channel", 8'h00, chan);
    check("threshold", 8'h00, thold);
    check("miso oe", 8'h00, {7'h00, miso_oe});
    check("symbol valid", 8'h00, {7'h00, sym_v});
  endtask

  task automatic t_setup;
    logic [7:0] d;
    wr(ADR_TX_CFG, 8'h3E);
    check("64 chip", 8'h01, {7'h00, c64});
    wr(ADR_TX_CFG, 8'h18);
    wr(ADR_FRAMING_CFG, 8'h80);
    check("any rate single", 8'h00, {7'h00, any_rate});
    wr(ADR_TX_CFG, 8'h16);
    check("32 chip", 8'h00, {7'h00, c64});
    check("any rate ddr", 8'h01, {7'h00, any_rate});
    check("framer on", 8'h01, {7'h00, fr_en});
    wr(ADR_RX_CFG, 8'h4B);
    wr(ADR_XACT_CFG, 8'h80);
    check("auto ack on", 8'h01, {7'h00, ack});
    wr(ADR_XACT_CFG, 8'h05);
    check("auto ack off", 8'h00, {7'h00, ack});
    wr(ADR_FRAMING_CFG, 8'h00);
    check("framer off", 8'h00, {7'h00, fr_en});
    wr(ADR_TX_OVR, 8'h04);
    check("tx crc", 8'h00, {7'h00, tx_crc});
    wr(ADR_RX_OVR, 8'h14);
    check("rx crc check", 8'h00, {7'h00, rx_crc});
    check("accept bad crc", 8'h01, {7'h00, rx_bad});
    // gfsk mode makes the crc enables live
    wr(ADR_TX_CFG, 8'h06);
    check("tx crc gfsk", 8'h00, {7'h00, tx_crc});
    check("rx crc gfsk", 8'h00, {7'h00, rx_crc});
    wr(ADR_TX_OVR, 8'h00);
    check("tx crc on", 8'h01, {7'h00, tx_crc});
    check("rx crc still off", 8'h00, {7'h00, rx_crc});
    wr(ADR_TX_OVR, 8'h04);
    wr(ADR_TX_CFG, 8'h16);
    wr(ADR_ANALOG, 8'h01);
    check("all slow", 8'h01, {7'h00, slow});
    wr(ADR_THOLD32, 8'h03);
    check("threshold", 8'h03, thold);
    wr(ADR_EOP_CTRL, 8'h01);
    check("eop symbols", 8'h01, eop);
    wr(ADR_PREAMBLE, 8'hAA);
    wr(ADR_PREAMBLE, 8'hAA);
    wr(ADR_PREAMBLE, 8'h05);
    rd(ADR_PREAMBLE, d);
    check("preamble count", 8'h05, d);
    wr(ADR_STATUS, 8'hFF);
    rd(ADR_STATUS, d);
    check("status", 8'h01, d);
    rd(ADR_TX_CFG, d);
    check("tx cfg readback", 8'h16, d);
  endtask

  task automatic t_channel;
    logic [7:0] d;
    wr(ADR_CHANNEL, 8'h61);
    rd(ADR_CHANNEL, d);
    check("top channel", 8'h61, d);
    wr(ADR_CHANNEL, 8'h62);
    check("clamped channel", 8'h61, chan);
    wr(ADR_CHANNEL, 8'h00);
    check("low channel", 8'h00, chan);
  endtask

  task automatic t_pins;
    logic [7:0] cfg [4] = '{8'h08, 8'h09, 8'h72, 8'hB2};
    logic [3:0] exp [4] = '{4'b1101, 4'b0010, 4'b1110, 4'b0001}; // tx active, irq, aux, amp
    logic last;
    int n;
    for (int i = 0; i < 4; i++) begin
      tx_act = exp[i][3];
      wr(ADR_AUX_CFG, cfg[i]);
      check("irq", {7'h00, exp[i][2]}, {7'h00, irq});
      check("aux", {7'h00, exp[i][1]}, {7'h00, aux});
      check("amp", {7'h00, exp[i][0]}, {7'h00, amp});
    end
    tx_act = 1'b0;
    wr(ADR_AUX_CFG, 8'h84);
    check("miso gpio high", 8'h01, {7'h00, miso});
    check("miso gpio oe", 8'h01, {7'h00, miso_oe});
    wr(ADR_AUX_CFG, 8'h04);
    check("miso gpio low", 8'h00, {7'h00, miso});
    wr(ADR_AUX_CFG, 8'h00);
    check("irq high idle", 8'h01, {7'h00, irq});
    n = 0;
    last = aux;
    repeat (64) begin
      @(negedge clk);
      if (aux !== last) n++;
      last = aux;
    end
    check("aux clock edges", 8'h10, n[7:0]);
  endtask

  task automatic t_ddr;
    logic [7:0] bytes [5] = '{8'hE4, 8'h1B, 8'hA5, 8'h3C, 8'hFF};
    logic [1:0] exp;
    int n;
    int k;
    wr(ADR_AUX_CFG, 8'h01);
    foreach (bytes[i]) wr(ADR_TX_DATA, bytes[i]); // last one meets a full buffer
    tx_act = 1'b1;
    n = 0;
    k = 0;
    while (k < 600) begin
      sym_rdy = (k % 3) != 0; // modem stalls every third cycle
      if (sym_v === 1'b1 && sym_rdy) begin
        exp = bytes[n / 4][7 - 2 * (n % 4) -: 2];
        check("symbol", {6'h00, exp}, {6'h00, sym});
        n++;
      end
      @(negedge clk);
      k++;
    end
    check("symbol count", 8'h10, n[7:0]);
    check("drained", 8'h00, {7'h00, sym_v});
    check("irq low idle", 8'h00, {7'h00, irq});
    sym_rdy = 1'b0;
    tx_act = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    tx_act = 1'b0;
    sym_rdy = 1'b0;
    repeat (2) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    t_reset();
    t_setup();
    t_channel();
    t_pins();
    t_ddr();
    summarize();
  end

  initial begin
    #500000;
    bad_count++;
    summarize();
  end
endmodule // tb_top
`default_nettype wire
